//--- hdl/tcr_config_regs.sv
// Configuration registers 2 to 6 of a UHF transceiver and the logic they steer.
// Assumes the serial port delivers decoded byte reads and writes, and that
// dclk_en pulses once per digital clock period.
//
// Contract
// - In receive, coding bit 0 raises interrupt on bit-check success; 1 does not.
// - In transmit, coding bit 0 sends Manchester; bit 1 sends NRZ.
// - High trim bits decode to 0, 128, 256, 384; default code 10.
// - External supply output follows its enable bit; default on.
// - Bit-check pass, key event or power-on status force both enables to 1.
// - Clock output pin gated by clock enable bit; default on.
// - Modulation type bit 0 selects FSK, 1 selects ASK.
// - Sleep time is count times 1024 digital clocks times extension; default 10.
// - Sleep extension factor 1 when bit clear, 8 when set.
// - Limit extension factor 1 or 2 scales extended clock.
// - Bit-check length 0, 3, 6 or 9 bits; default 3.
// - Minimum pulse limit is min value times extended period; default 16.
// - Transmit half-bit is (min value plus one) extended periods.
// - Extended period is 8, 4, 2, 1 digital clocks times limit factor.
// - Maximum pulse limit is (max value minus one) extended periods; default 28.
`include "tcr_params.svh"
`timescale 1ns/1ps
`default_nettype none

module tcr_config_regs #(
	parameter int SLEEP_W = 18
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic dclk_en,
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wr_data,
	output logic [7:0] reg_rd_data_ff,
	input wire logic [1:0] op_mode,
	input wire logic key_event,
	input wire logic power_on_status,
	input wire logic irq_clear,
	output logic irq_ff,
	input wire logic clk_src,
	output logic clk_out_pin_ff,
	output logic ext_supply_pin_ff,
	output logic [8:0] freq_trim_high_value_ff,
	output logic modulation_ask_ff,
	input wire logic sleep_start,
	output logic sleep_done_ff,
	input wire logic bitcheck_start,
	input wire logic rx_edge,
	output logic bitcheck_pass_ff,
	output logic bitcheck_fail_ff,
	input wire logic tx_enable,
	input wire logic tx_data,
	output logic tx_bit_take_ff,
	output logic tx_mod_ff
);

	// ****************************************
	// Register storage
	// ****************************************
	logic [7:0] freq_low_and_coding_ctrl_ff;
	logic [3:0] freq_high_supply_clock_ctrl_ff;
	logic [7:0] modulation_sleep_ctrl_ff;
	logic [7:0] check_count_min_limit_ctrl_ff;
	logic [7:0] baud_range_max_limit_ctrl_ff;
	logic force_enables;
	logic pass_pulse;
	logic in_rx;
	logic in_tx;

	assign in_rx = (op_mode == tcr_pkg::TCR_OPM_RX) ||
		(op_mode == tcr_pkg::TCR_OPM_POLL);
	assign in_tx = (op_mode == tcr_pkg::TCR_OPM_TX);
	assign force_enables = (pass_pulse && in_rx) || key_event ||
		power_on_status;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			freq_low_and_coding_ctrl_ff <= `TCR_RST_FREQ_LOW_CODING;
			modulation_sleep_ctrl_ff <= `TCR_RST_MOD_SLEEP;
			check_count_min_limit_ctrl_ff <= `TCR_RST_CHECK_MIN;
			baud_range_max_limit_ctrl_ff <= `TCR_RST_BAUD_MAX;
		end else if (reg_wr_en) begin
			unique case (reg_addr)
				`TCR_OFS_FREQ_LOW_CODING: begin
					freq_low_and_coding_ctrl_ff <= reg_wr_data;
				end
				`TCR_OFS_MOD_SLEEP: begin
					modulation_sleep_ctrl_ff <= reg_wr_data;
				end
				`TCR_OFS_CHECK_MIN: begin
					check_count_min_limit_ctrl_ff <= reg_wr_data;
				end
				`TCR_OFS_BAUD_MAX: begin
					baud_range_max_limit_ctrl_ff <= reg_wr_data;
				end
				default: begin
				end
			endcase
		end
	end

	// Forcing wins over a write in the same cycle
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			freq_high_supply_clock_ctrl_ff <=
				4'(`TCR_RST_FREQ_HIGH_SUPPLY & `TCR_CR3_USED_MASK);
		end else begin
			if (reg_wr_en && reg_addr == `TCR_OFS_FREQ_HIGH_SUPPLY) begin
				freq_high_supply_clock_ctrl_ff <= reg_wr_data[3:0];
			end
			if (force_enables) begin
				freq_high_supply_clock_ctrl_ff[`TCR_BIT_EXT_SUPPLY_EN] <= 1'b1;
				freq_high_supply_clock_ctrl_ff[`TCR_BIT_CLK_OUT_EN] <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rd_data_ff <= 8'h00;
		end else if (reg_rd_en) begin
			unique case (reg_addr)
				`TCR_OFS_FREQ_LOW_CODING: begin
					reg_rd_data_ff <= freq_low_and_coding_ctrl_ff;
				end
				`TCR_OFS_FREQ_HIGH_SUPPLY: begin
					reg_rd_data_ff <= {4'h0, freq_high_supply_clock_ctrl_ff};
				end
				`TCR_OFS_MOD_SLEEP: begin
					reg_rd_data_ff <= modulation_sleep_ctrl_ff;
				end
				`TCR_OFS_CHECK_MIN: begin
					reg_rd_data_ff <= check_count_min_limit_ctrl_ff;
				end
				`TCR_OFS_BAUD_MAX: begin
					reg_rd_data_ff <= baud_range_max_limit_ctrl_ff;
				end
				default: begin
					reg_rd_data_ff <= 8'h00;
				end
			endcase
		end
	end

	// ****************************************
	// Field decode
	// ****************************************
	logic coding_sel;
	logic [1:0] freq_trim_code;
	logic [4:0] sleep_count;
	logic sleep_extend;
	logic limit_extend;
	logic [1:0] check_code;
	logic [5:0] min_limit;
	logic [1:0] baud_range;
	logic [5:0] max_limit;

	assign coding_sel = freq_low_and_coding_ctrl_ff[`TCR_BIT_CODING_SEL];
	assign freq_trim_code = {
		freq_high_supply_clock_ctrl_ff[`TCR_BIT_FREQ_TRIM_BIT8],
		freq_high_supply_clock_ctrl_ff[`TCR_BIT_FREQ_TRIM_BIT7]};
	assign sleep_count = modulation_sleep_ctrl_ff[`TCR_POS_SLEEP_LSB +: 5];
	assign sleep_extend = modulation_sleep_ctrl_ff[`TCR_BIT_SLEEP_EXTEND];
	assign limit_extend = modulation_sleep_ctrl_ff[`TCR_BIT_LIMIT_EXTEND];
	assign check_code = {
		check_count_min_limit_ctrl_ff[`TCR_BIT_CHECK_COUNT_HI],
		check_count_min_limit_ctrl_ff[`TCR_BIT_CHECK_COUNT_LO]};
	assign min_limit = check_count_min_limit_ctrl_ff[5:0];
	assign baud_range = baud_range_max_limit_ctrl_ff[`TCR_POS_BAUD_LSB +: 2];
	assign max_limit = baud_range_max_limit_ctrl_ff[5:0];

	// ****************************************
	// Static outputs
	// ****************************************
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			freq_trim_high_value_ff <= 9'h000;
			ext_supply_pin_ff <= 1'b0;
			clk_out_pin_ff <= 1'b0;
			modulation_ask_ff <= 1'b0;
		end else begin
			freq_trim_high_value_ff <= 9'(freq_trim_code) *
				`TCR_FREQ_TRIM_HIGH_VALUE_STEP;
			ext_supply_pin_ff <=
				freq_high_supply_clock_ctrl_ff[`TCR_BIT_EXT_SUPPLY_EN];
			clk_out_pin_ff <= clk_src &
				freq_high_supply_clock_ctrl_ff[`TCR_BIT_CLK_OUT_EN];
			modulation_ask_ff <=
				modulation_sleep_ctrl_ff[`TCR_BIT_MODULATION_TYPE];
		end
	end

	// ****************************************
	// Extended clock
	// ****************************************
	logic [4:0] xdclk_period;
	logic xdclk_tick;

	// Base 8/4/2/1 for codes 00..11, doubled by the limit factor
	assign xdclk_period = 5'(5'h08 >> baud_range) << limit_extend;

	tcr_tick_div #(.W(5)) u_xdclk (
		.clk(clk),
		.arst_n(arst_n),
		.restart(1'b0),
		.step_en(dclk_en),
		.period(xdclk_period),
		.tick(xdclk_tick)
	);

	// ****************************************
	// Sleep timer
	// ****************************************
	logic [SLEEP_W-1:0] sleep_period;
	logic sleep_tick;
	logic sleep_run_ff;

	assign sleep_period = SLEEP_W'(SLEEP_W'(sleep_count) * `TCR_SLEEP_UNIT) <<
		(sleep_extend ? `TCR_SLEEP_EXT_SHIFT : 0);

	tcr_tick_div #(.W(SLEEP_W)) u_sleep (
		.clk(clk),
		.arst_n(arst_n),
		.restart(sleep_start),
		.step_en(dclk_en && sleep_run_ff),
		.period(sleep_period),
		.tick(sleep_tick)
	);

	// Count 0 ends the sleep at once
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sleep_run_ff <= 1'b0;
			sleep_done_ff <= 1'b0;
		end else if (sleep_start) begin
			sleep_run_ff <= (sleep_count != 5'h00);
			sleep_done_ff <= (sleep_count == 5'h00);
		end else begin
			sleep_done_ff <= sleep_run_ff && sleep_tick;
			if (sleep_tick) begin
				sleep_run_ff <= 1'b0;
			end
		end
	end

	// ****************************************
	// Bit-check
	// ****************************************
	tcr_pkg::tcr_chk_state_t chk_state_ff;
	logic [6:0] interval_ff;
	logic [3:0] bits_left_ff;
	logic [3:0] check_len;
	logic in_window;
	logic too_long;

	assign check_len = 4'(check_code * `TCR_CHECK_STEP);
	// Interval measured in extended clock periods
	assign in_window = (interval_ff >= 7'(min_limit)) &&
		(interval_ff + 7'h01 <= 7'(max_limit));
	assign too_long = (interval_ff + 7'h01 > 7'(max_limit));
	assign pass_pulse = bitcheck_pass_ff;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			chk_state_ff <= tcr_pkg::TCR_CHK_IDLE;
			interval_ff <= 7'h00;
			bits_left_ff <= 4'h0;
			bitcheck_pass_ff <= 1'b0;
			bitcheck_fail_ff <= 1'b0;
		end else begin
			bitcheck_pass_ff <= 1'b0;
			bitcheck_fail_ff <= 1'b0;
			unique case (chk_state_ff)
				tcr_pkg::TCR_CHK_IDLE: begin
					if (bitcheck_start && in_rx) begin
						bits_left_ff <= check_len;
						if (check_len == 4'h0) begin
							bitcheck_pass_ff <= 1'b1;
						end else begin
							chk_state_ff <= tcr_pkg::TCR_CHK_FIRST;
						end
					end
				end
				tcr_pkg::TCR_CHK_FIRST: begin
					interval_ff <= 7'h00;
					if (!in_rx) begin
						chk_state_ff <= tcr_pkg::TCR_CHK_IDLE;
					end else if (rx_edge) begin
						chk_state_ff <= tcr_pkg::TCR_CHK_RUN;
					end
				end
				tcr_pkg::TCR_CHK_RUN: begin
					if (!in_rx) begin
						chk_state_ff <= tcr_pkg::TCR_CHK_IDLE;
					end else if (rx_edge) begin
						interval_ff <= 7'h00;
						if (!in_window) begin
							bitcheck_fail_ff <= 1'b1;
							chk_state_ff <= tcr_pkg::TCR_CHK_IDLE;
						end else if (bits_left_ff == 4'h1) begin
							bitcheck_pass_ff <= 1'b1;
							chk_state_ff <= tcr_pkg::TCR_CHK_IDLE;
						end else begin
							bits_left_ff <= bits_left_ff - 4'h1;
						end
					end else if (too_long) begin
						// No edge before the maximum limit
						bitcheck_fail_ff <= 1'b1;
						chk_state_ff <= tcr_pkg::TCR_CHK_IDLE;
					end else if (xdclk_tick) begin
						interval_ff <= interval_ff + 7'h01;
					end
				end
				default: begin
					chk_state_ff <= tcr_pkg::TCR_CHK_IDLE;
				end
			endcase
		end
	end

	// ****************************************
	// Interrupt
	// ****************************************
	// Set wins over a clear in the same cycle
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_ff <= 1'b0;
		end else if (bitcheck_pass_ff && in_rx && !coding_sel) begin
			irq_ff <= 1'b1;
		end else if (irq_clear) begin
			irq_ff <= 1'b0;
		end
	end

	// ****************************************
	// Transmit coder
	// ****************************************
	logic half_tick;
	logic phase_ff;
	logic bit_ff;
	logic tx_run;

	assign tx_run = in_tx && tx_enable;

	tcr_tick_div #(.W(7)) u_half_bit (
		.clk(clk),
		.arst_n(arst_n),
		.restart(!tx_run),
		.step_en(xdclk_tick),
		.period(7'(min_limit) + 7'h01),
		.tick(half_tick)
	);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			phase_ff <= 1'b0;
			bit_ff <= 1'b0;
			tx_bit_take_ff <= 1'b0;
			tx_mod_ff <= 1'b0;
		end else if (!tx_run) begin
			phase_ff <= 1'b0;
			tx_bit_take_ff <= 1'b0;
			tx_mod_ff <= 1'b0;
		end else begin
			tx_bit_take_ff <= half_tick && !phase_ff;
			if (half_tick) begin
				phase_ff <= !phase_ff;
				if (!phase_ff) begin
					bit_ff <= tx_data;
					tx_mod_ff <= tx_data;
				end else begin
					// NRZ holds the bit for both halves
					tx_mod_ff <= coding_sel ? bit_ff : !bit_ff;
				end
			end
		end
	end

endmodule : tcr_config_regs

`default_nettype wire

//--- hdl/tcr_params.svh
// Constants of the transceiver configuration register bank.
// Assumes byte-wide register accesses already decoded from the serial port.
`ifndef TCR_PARAMS_SVH
`define TCR_PARAMS_SVH

// ****************************************
// Register offsets
// ****************************************
`define TCR_OFS_FREQ_LOW_CODING 4'h1
`define TCR_OFS_FREQ_HIGH_SUPPLY 4'h2
`define TCR_OFS_MOD_SLEEP 4'h3
`define TCR_OFS_CHECK_MIN 4'h4
`define TCR_OFS_BAUD_MAX 4'h5

// ****************************************
// Reset values
// ****************************************
`define TCR_RST_FREQ_LOW_CODING 8'hB0
`define TCR_RST_FREQ_HIGH_SUPPLY 8'h0B
`define TCR_RST_MOD_SLEEP 8'h28
`define TCR_RST_CHECK_MIN 8'h50
`define TCR_RST_BAUD_MAX 8'h9C

// ****************************************
// Field positions
// ****************************************
`define TCR_BIT_CODING_SEL 0
`define TCR_BIT_FREQ_TRIM_BIT8 3
`define TCR_BIT_FREQ_TRIM_BIT7 2
`define TCR_BIT_EXT_SUPPLY_EN 1
`define TCR_BIT_CLK_OUT_EN 0
`define TCR_BIT_MODULATION_TYPE 7
`define TCR_POS_SLEEP_LSB 2
`define TCR_BIT_SLEEP_EXTEND 1
`define TCR_BIT_LIMIT_EXTEND 0
`define TCR_BIT_CHECK_COUNT_HI 7
`define TCR_BIT_CHECK_COUNT_LO 6
`define TCR_POS_BAUD_LSB 6
`define TCR_CR3_USED_MASK 8'h0F

// ****************************************
// Factors and counts
// ****************************************
`define TCR_FREQ_TRIM_HIGH_VALUE_STEP 9'h080
`define TCR_SLEEP_UNIT 18'h00400
`define TCR_SLEEP_EXT_SHIFT 3
`define TCR_CHECK_STEP 4'h3

`endif

//--- hdl/tcr_pkg.sv
// Types of the transceiver configuration register bank.
// Assumes nothing beyond the params header.
package tcr_pkg;

	typedef enum logic [1:0] {
		TCR_OPM_IDLE = 2'b00,
		TCR_OPM_TX = 2'b01,
		TCR_OPM_POLL = 2'b10,
		TCR_OPM_RX = 2'b11
	} tcr_opmode_t;

	typedef enum logic [1:0] {
		TCR_CHK_IDLE = 2'b00,
		TCR_CHK_FIRST = 2'b01,
		TCR_CHK_RUN = 2'b10
	} tcr_chk_state_t;

endpackage : tcr_pkg

//--- hdl/tcr_tick_div.sv
// Programmable tick divider: one tick every period steps.
// Assumes step_en is a one-cycle enable in the clk domain.
`timescale 1ns/1ps
`default_nettype none

module tcr_tick_div #(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic restart,
	input wire logic step_en,
	input wire logic [W-1:0] period,
	output logic tick
);

	logic [W-1:0] cnt_ff;

	// Period 0 behaves as 1 so the divider never stalls
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_ff <= '0;
			tick <= 1'b0;
		end else if (restart) begin
			cnt_ff <= '0;
			tick <= 1'b0;
		end else if (step_en) begin
			if (cnt_ff + W'(1) >= period) begin
				cnt_ff <= '0;
				tick <= 1'b1;
			end else begin
				cnt_ff <= cnt_ff + W'(1);
				tick <= 1'b0;
			end
		end else begin
			tick <= 1'b0;
		end
	end

endmodule : tcr_tick_div

`default_nettype wire

//--- tb/tcr_config_regs_asserts.sv
// Port checker for the transceiver configuration register bank.
// Assumes it is bound to tcr_config_regs and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
// ****
// Checker
// ****
module tcr_config_regs_asserts #(
	parameter int SLEEP_W = 18
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wr_data,
	input wire logic [7:0] reg_rd_data_ff,
	input wire logic [1:0] op_mode,
	input wire logic key_event,
	input wire logic power_on_status,
	input wire logic irq_clear,
	input wire logic irq_ff,
	input wire logic clk_src,
	input wire logic clk_out_pin_ff,
	input wire logic ext_supply_pin_ff,
	input wire logic [8:0] freq_trim_high_value_ff,
	input wire logic sleep_done_ff,
	input wire logic bitcheck_pass_ff,
	input wire logic bitcheck_fail_ff
);
	logic coding_ff;
	// Shadow of the coding bit, the interrupt depends on it
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			coding_ff <= 1'b0;
		end else if (reg_wr_en && reg_addr == 4'h1) begin
			coding_ff <= reg_wr_data[0];
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	sequence force_src;
		key_event || power_on_status || (bitcheck_pass_ff && op_mode[1]);
	endsequence
	sequence pass_irq;
		bitcheck_pass_ff && op_mode[1] && !coding_ff;
	endsequence
	chk_pass_irq: assert property (pass_irq |=> irq_ff)
		else $error("irq not raised after pass");
	chk_irq_hold: assert property (irq_ff && !irq_clear |=> irq_ff)
		else $error("irq dropped without clear");
	chk_irq_cause: assert property ($rose(irq_ff) |-> $past(bitcheck_pass_ff))
		else $error("irq rose without pass");
	chk_force_en: assert property (force_src |-> ##[0:3] ext_supply_pin_ff)
		else $error("supply not forced on");
	chk_clk_gate: assert property (clk_out_pin_ff |-> $past(clk_src))
		else $error("clock out without source");
	chk_cr3_upper: assert property (reg_rd_en && reg_addr == 4'h2 |=> reg_rd_data_ff[7:4] == 4'h0)
		else $error("register 3 upper bits not zero");
	chk_trim_steps: assert property (freq_trim_high_value_ff[6:0] == 7'h00)
		else $error("trim value off its steps");
	chk_pass_fail: assert property (!(bitcheck_pass_ff && bitcheck_fail_ff))
		else $error("pass and fail together");
	chk_sleep_pulse: assert property (sleep_done_ff |=> !sleep_done_ff)
		else $error("sleep done longer than a cycle");
endmodule : tcr_config_regs_asserts

bind tcr_config_regs tcr_config_regs_asserts #(.SLEEP_W(SLEEP_W)) chk_inst (
	.clk, .arst_n, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wr_data,
	.reg_rd_data_ff, .op_mode, .key_event, .power_on_status, .irq_clear,
	.irq_ff, .clk_src, .clk_out_pin_ff, .ext_supply_pin_ff,
	.freq_trim_high_value_ff, .sleep_done_ff, .bitcheck_pass_ff,
	.bitcheck_fail_ff
);
`default_nettype wire

//--- tb/tcr_mcu_model.sv
// Controller model: byte writes and reads on the decoded register port.
// Assumes one clock; requests change just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
// ****
// Controller
// ****
module tcr_mcu_model (
	input wire logic clk,
	input wire logic aux_mode,
	input wire logic rx_ask,
	input wire logic [7:0] reg_rd_data_ff,
	output logic reg_wr_en,
	output logic reg_rd_en,
	output logic [3:0] reg_addr,
	output logic [7:0] reg_wr_data
);
	initial begin
		reg_wr_en = 1'b0;
		reg_rd_en = 1'b0;
		reg_addr = 4'h0;
		reg_wr_data = 8'h00;
	end
	task wr(input logic [3:0] a, input logic [7:0] d);
		logic [7:0] v;
		v = d;
		if (aux_mode && a == 4'h2) v[1] = 1'b1;
		if (rx_ask && a == 4'h5 && v[7:6] == 2'b11) v[7:6] = 2'b10;
		@(posedge clk);
		reg_wr_en <= 1'b1;
		reg_addr <= a;
		reg_wr_data <= v;
		@(posedge clk);
		reg_wr_en <= 1'b0;
		// Idle data is inverted so stale bytes never look valid
		reg_wr_data <= ~v;
	endtask : wr
	task rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_rd_en <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd_en <= 1'b0;
		@(posedge clk);
		#1;
		d = reg_rd_data_ff;
	endtask : rd
endmodule : tcr_mcu_model
`default_nettype wire

//--- tb/tb_transceiver_config_regs.sv
// Testbench for the transceiver configuration register bank.
// Assumes dclk_en high every cycle, so one digital clock is one cycle.
`timescale 1ns/1ps
`default_nettype none
// ****
// Bench
// ****
module tb_transceiver_config_regs;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic dclk_en = 1'b1;
	logic reg_wr_en, reg_rd_en, irq_ff, clk_out_pin_ff, ext_supply_pin_ff;
	logic [3:0] reg_addr;
	logic [7:0] reg_wr_data, reg_rd_data_ff, d;
	logic [1:0] op_mode = 2'b00;
	logic key_event = 1'b0, power_on_status = 1'b0, irq_clear = 1'b0;
	logic clk_src = 1'b0, sleep_start = 1'b0, bitcheck_start = 1'b0;
	logic rx_edge = 1'b0, tx_enable = 1'b0, tx_data = 1'b1;
	logic modulation_ask_ff, sleep_done_ff, bitcheck_pass_ff, bitcheck_fail_ff;
	logic tx_bit_take_ff, tx_mod_ff;
	logic [8:0] freq_trim_high_value_ff;
	int err_total = 0, total_checks = 0, npass = 0, nfail = 0, n, i;
	tcr_config_regs tcr_config_regs_inst (.clk, .arst_n, .dclk_en, .reg_wr_en,
		.reg_rd_en, .reg_addr, .reg_wr_data, .reg_rd_data_ff, .op_mode,
		.key_event, .power_on_status, .irq_clear, .irq_ff, .clk_src,
		.clk_out_pin_ff, .ext_supply_pin_ff, .freq_trim_high_value_ff,
		.modulation_ask_ff, .sleep_start, .sleep_done_ff, .bitcheck_start,
		.rx_edge, .bitcheck_pass_ff, .bitcheck_fail_ff, .tx_enable, .tx_data,
		.tx_bit_take_ff, .tx_mod_ff);
	tcr_mcu_model mcu_inst (.clk, .aux_mode(1'b0),
		.rx_ask(op_mode == 2'b11 && modulation_ask_ff),
		.reg_rd_data_ff, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wr_data);
	always #2.5 clk = ~clk;
	always @(posedge clk) begin
		clk_src <= ~clk_src;
		npass <= npass + int'(bitcheck_pass_ff === 1'b1);
		nfail <= nfail + int'(bitcheck_fail_ff === 1'b1);
	end
	task chk(input logic [15:0] g, input logic [15:0] e);
		total_checks++;
		if (g !== e) begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task report_and_stop;
		if (err_total == 0 && total_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : report_and_stop
	task rd_chk(input logic [3:0] a, input logic [7:0] e);
		mcu_inst.rd(a, d);
		chk(16'(d), 16'(e));
	endtask : rd_chk
	task settle;
		repeat (3) @(posedge clk);
		#1;
	endtask : settle
	task wait_for(input int sel, input int lim, output int c);
		for (c = 1; c <= lim; c++) begin
			@(posedge clk);
			#1;
			if (sel == 0 && sleep_done_ff === 1'b1) break;
			if (sel == 1 && tx_bit_take_ff === 1'b1) break;
		end
		if (c > lim) begin
			err_total++;
			report_and_stop();
		end
	endtask : wait_for
	// Edge spacing is gap plus one cycles; tail lets a timeout fail land
	task bchk(input int gap, input int k, input int ep, input int ef);
		int p0, f0;
		p0 = npass;
		f0 = nfail;
		@(posedge clk);
		bitcheck_start <= 1'b1;
		@(posedge clk);
		bitcheck_start <= 1'b0;
		repeat (k) begin
			repeat (gap) @(posedge clk);
			rx_edge <= 1'b1;
			@(posedge clk);
			rx_edge <= 1'b0;
		end
		repeat (120) @(posedge clk);
		#1;
		chk(16'(npass - p0), 16'(ep));
		chk(16'(nfail - f0), 16'(ef));
	endtask : bchk
	task tog(output int t);
		logic p;
		t = 0;
		wait_for(1, 300, n);
		p = tx_mod_ff;
		repeat (68) begin
			@(posedge clk);
			#1;
			if (tx_mod_ff !== p) t++;
			p = tx_mod_ff;
		end
	endtask : tog
	initial begin
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		rd_chk(4'h1, 8'hB0);
		rd_chk(4'h2, 8'h0B);
		rd_chk(4'h3, 8'h28);
		rd_chk(4'h4, 8'h50);
		rd_chk(4'h5, 8'h9C);
		rd_chk(4'h0, 8'h00);
		rd_chk(4'h6, 8'h00);
		chk(16'(freq_trim_high_value_ff), 16'h0100);
		for (i = 0; i < 4; i++) begin
			mcu_inst.wr(4'h2, {4'hF, 2'(i), 2'b11});
			settle();
			chk(16'(freq_trim_high_value_ff), 16'(i * 128));
		end
		rd_chk(4'h2, 8'h0F);
		mcu_inst.wr(4'h2, 8'h08);
		settle();
		chk(16'(ext_supply_pin_ff), 16'h0000);
		repeat (2) begin
			@(posedge clk);
			#1;
			chk(16'(clk_out_pin_ff), 16'h0000);
		end
		@(posedge clk);
		key_event <= 1'b1;
		@(posedge clk);
		key_event <= 1'b0;
		settle();
		chk(16'(ext_supply_pin_ff), 16'h0001);
		chk(16'(clk_out_pin_ff), 16'(!clk_src));
		power_on_status <= 1'b1;
		mcu_inst.wr(4'h2, 8'h08);
		rd_chk(4'h2, 8'h0B);
		power_on_status <= 1'b0;
		mcu_inst.wr(4'h3, 8'hA8);
		settle();
		chk(16'(modulation_ask_ff), 16'h0001);
		mcu_inst.wr(4'h3, 8'h04);
		settle();
		chk(16'(modulation_ask_ff), 16'h0000);
		@(posedge clk);
		sleep_start <= 1'b1;
		@(posedge clk);
		sleep_start <= 1'b0;
		wait_for(0, 2000, n);
		chk(16'(n >= 1020 && n <= 1030), 16'h0001);
		mcu_inst.wr(4'h3, 8'h06);
		@(posedge clk);
		sleep_start <= 1'b1;
		@(posedge clk);
		sleep_start <= 1'b0;
		wait_for(0, 9000, n);
		chk(16'(n >= 8188 && n <= 8198), 16'h0001);
		mcu_inst.wr(4'h3, 8'h28);
		mcu_inst.wr(4'h2, 8'h08);
		mcu_inst.wr(4'h4, 8'h10);
		op_mode <= 2'b11;
		bchk(1, 0, 1, 0);
		chk(16'(irq_ff), 16'h0001);
		rd_chk(4'h2, 8'h0B);
		irq_clear <= 1'b1;
		mcu_inst.wr(4'h1, 8'hB1);
		irq_clear <= 1'b0;
		bchk(1, 0, 1, 0);
		chk(16'(irq_ff), 16'h0000);
		mcu_inst.wr(4'h1, 8'hB0);
		mcu_inst.wr(4'h4, 8'h50);
		bchk(39, 4, 1, 0);
		bchk(19, 4, 0, 1);
		bchk(39, 1, 0, 1);
		mcu_inst.wr(4'h5, 8'hDC);
		bchk(19, 4, 1, 0);
		bchk(39, 4, 0, 1);
		mcu_inst.wr(4'h5, 8'h9C);
		mcu_inst.wr(4'h3, 8'h29);
		bchk(39, 4, 0, 1);
		bchk(79, 4, 1, 0);
		mcu_inst.wr(4'h2, 8'h08);
		op_mode <= 2'b10;
		bchk(79, 4, 1, 0);
		rd_chk(4'h2, 8'h0B);
		op_mode <= 2'b01;
		tx_enable <= 1'b1;
		wait_for(1, 300, n);
		wait_for(1, 300, n);
		chk(16'(n), 16'd136);
		mcu_inst.wr(4'h3, 8'h28);
		// First bit after a rate change may be short
		wait_for(1, 300, n);
		wait_for(1, 300, n);
		wait_for(1, 300, n);
		chk(16'(n), 16'd68);
		tog(n);
		chk(16'(n), 16'd2);
		mcu_inst.wr(4'h1, 8'hB1);
		wait_for(1, 300, n);
		tog(n);
		chk(16'(n), 16'd0);
		chk(16'(tx_mod_ff), 16'h0001);
		report_and_stop();
	end
endmodule : tb_transceiver_config_regs
`default_nettype wire
